// File: shared/pm_pkg.sv
// Constants, field layouts and state carriers for the switch power-management block.
// Assumes a single core clock of 20 MHz shared by every file that imports it.
package pm_pkg;
	localparam int NDS = 3;
	localparam int CLK_MHZ = 20;

	// Register offsets.
	localparam logic [11:0] OFF_SLOT    = 12'h080;
	localparam logic [11:0] OFF_PB_HDR  = 12'h138;
	localparam logic [11:0] OFF_PB_SEL  = 12'h13c;
	localparam logic [11:0] OFF_PB_DATA = 12'h140;
	localparam logic [11:0] OFF_PB_CAP  = 12'h144;
	localparam logic [11:0] OFF_USER    = 12'h1e0;

	// Slot control and status fields.
	localparam int SC_FAULT_EN  = 1;
	localparam int SC_IND_LO    = 8;
	localparam int SC_PWR_CTRL  = 10;
	localparam int SS_LO        = 16;
	localparam logic [1:0] IND_KEEP  = 2'h0;
	localparam logic [1:0] IND_ON    = 2'h1;
	localparam logic [1:0] IND_BLINK = 2'h2;
	localparam logic [1:0] IND_OFF   = 2'h3;

	// User configuration fields.
	localparam int UC_IDLE_SEL   = 0;
	localparam int UC_TURNOFF_EN = 2;
	localparam int UC_BLOCK      = 10;

	// Power budget capability.
	localparam logic [15:0] PB_CAP_ID = 16'h0004;
	localparam logic [3:0]  PB_VER    = 4'h1;
	localparam logic [11:0] PB_NEXT   = 12'h148;
	localparam int PB_WORDS = 8;

	// Device power states.
	localparam logic [1:0] DSTATE_D0    = 2'h0;
	localparam logic [1:0] DSTATE_D3HOT = 2'h3;

	// Timing, as times and derived cycle counts; least times round up.
	localparam int IDLE_SHORT_NS = 1000;
	localparam int IDLE_LONG_NS  = 4000;
	localparam int PWR_ON_NS     = 100000;
	localparam int IDLE_SHORT_CYC = (IDLE_SHORT_NS * CLK_MHZ + 999) / 1000;
	localparam int IDLE_LONG_CYC  = (IDLE_LONG_NS * CLK_MHZ + 999) / 1000;
	localparam int PWR_ON_CYC     = (PWR_ON_NS * CLK_MHZ + 999) / 1000;
	localparam logic [6:0]  IDLE_SHORT_LAST = 7'(IDLE_SHORT_CYC - 1);
	localparam logic [6:0]  IDLE_LONG_LAST  = 7'(IDLE_LONG_CYC - 1);
	localparam logic [11:0] PWR_ON_LAST     = 12'(PWR_ON_CYC - 1);

	typedef enum logic [2:0] {LNK_DOWN, LNK_L0, LNK_L0S, LNK_L1, LNK_L23} link_e;
	typedef enum logic [1:0] {UP_L0, UP_L0S, UP_L1} up_e;

	typedef struct packed {
		logic [10:0] rsvd;
		logic [2:0]  rail;
		logic [2:0]  condType;
		logic [1:0]  pmState;
		logic [2:0]  subState;
		logic [1:0]  scale;
		logic [7:0]  basePower;
	} pb_word_s;

	typedef struct packed {
		logic       hotplugCapable;
		logic       slotPresenceInput;
		logic       rxDetect;
		logic       buttonPress;
		logic       powerFault;
		logic       retentionLatchChange;
		logic       bwMgmt;
		logic       bwAuto;
		logic       dllChange;
		logic [1:0] powerState;
		logic       wakeMessageEnable;
		logic       wakeClear;
	} slot_in_s;

	typedef struct packed {
		logic        faultEn;
		logic [1:0]  indicator;
		logic        pwrCtrl;
		logic [4:0]  status;
		logic        presLast;
		logic        wakeEventFlag;
		logic        pme;
		logic        irq;
		logic        turnOff;
		logic        pwrOn;
		logic [11:0] cnt;
	} slot_st_s;

	typedef struct packed {
		logic [6:0] cnt;
		logic       met;
	} idle_st_s;

	typedef struct packed {
		up_e                     up;
		logic [7:0]              pbIndex;
		logic                    idleSel;
		logic                    turnoffEn;
		logic                    standbyBlock;
		pb_word_s [PB_WORDS-1:0] pb;
		logic                    sysAlloc;
		logic [NDS-1:0]          acked;
		logic                    toArmed;
		logic                    ackSent;
		logic                    portDown;
		logic                    upAck;
		logic [NDS-1:0]          dsL1Exit;
		logic                    enterL23;
		logic                    ack;
		logic [31:0]             rdata;
	} main_st_s;

	localparam slot_st_s SLOT_RST = '{indicator: IND_OFF, pwrCtrl: 1'b1, default: '0};
	localparam idle_st_s IDLE_RST = '0;
	localparam main_st_s MAIN_RST = '0;
endpackage

// File: src/idle_timer.sv
// Counts continuous idle cycles on the upstream link for low-power standby entry.
// Assumes idle is a synchronous level; any busy cycle restarts the count.
`timescale 1ns/1ns
module idle_timer
	import pm_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Idle tracking
	input  wire logic idle,
	input  wire logic longSel,
	output idle_st_s  st
);
	idle_st_s   next_st;
	logic [6:0] limit;

	always_comb begin
		limit = longSel ? IDLE_LONG_LAST : IDLE_SHORT_LAST;
		next_st = st;
		if (!idle) begin
			next_st = IDLE_RST;
		end else if (st.cnt == limit) begin
			next_st.met = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 7'h01;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			st <= IDLE_RST;
		else
			st <= next_st;
	end

	a_idle_short: assert property (@(posedge clk) disable iff (!rstn)
		$rose(st.met) && !$past(longSel) |-> $past(idle, 20) && !$past(st.met, 2))
		else $error("Standby idle time reached too early.");
endmodule

// File: src/slot_event_unit.sv
// Slot control, slot status and wake events of one downstream port, hot-plug capable or not.
// Assumes slot inputs are synchronous; event inputs are one-cycle strobes.
`timescale 1ns/1ns
module slot_event_unit
	import pm_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Register access
	input  wire logic        wrEn,
	input  wire logic [31:0] wdata,
	input  wire logic        turnoffEn,
	// Slot side
	input  wire slot_in_s    sin,
	// State
	output slot_st_s         st
);
	slot_st_s   next_st;
	logic       presence;
	logic       presChg;
	logic       cmdEv;
	logic       d3;
	logic       ev;
	logic       faultNote;
	logic [4:0] setBits;
	logic [4:0] clrBits;

	always_comb begin
		presence = sin.hotplugCapable ? (sin.slotPresenceInput | sin.rxDetect) : sin.rxDetect;
		presChg = presence != st.presLast;
		cmdEv = wrEn && (wdata[SC_IND_LO +: 2] != IND_KEEP);
		d3 = sin.powerState == DSTATE_D3HOT;
		ev = sin.hotplugCapable ? (presChg | sin.buttonPress | sin.powerFault |
			sin.retentionLatchChange | cmdEv | sin.bwMgmt | sin.bwAuto) :
			(presChg | sin.dllChange);
		faultNote = sin.hotplugCapable && sin.powerFault && st.faultEn;
		setBits = sin.hotplugCapable ? {cmdEv, presChg, sin.retentionLatchChange,
			sin.powerFault, sin.buttonPress} : 5'h00;
		clrBits = wrEn ? wdata[SS_LO +: 5] : 5'h00;
		next_st = st;
		next_st.presLast = presence;
		// A new event wins over a write-one clear in the same cycle.
		next_st.status = (st.status & ~clrBits) | setBits;
		next_st.wakeEventFlag = (st.wakeEventFlag & ~sin.wakeClear) | (d3 & ev);
		next_st.pme = d3 && ((ev && sin.wakeMessageEnable) || faultNote);
		next_st.irq = faultNote && (sin.powerState == DSTATE_D0);
		next_st.turnOff = 1'b0;
		if (wrEn) begin
			next_st.faultEn = wdata[SC_FAULT_EN];
			next_st.pwrCtrl = wdata[SC_PWR_CTRL];
			next_st.turnOff = turnoffEn && wdata[SC_PWR_CTRL] && !st.pwrCtrl;
		end
		if (cmdEv)
			next_st.indicator = wdata[SC_IND_LO +: 2];
		// Power drops one cycle after the write, so any turn-off message leaves first.
		if (st.pwrCtrl) begin
			next_st.pwrOn = 1'b0;
			next_st.cnt = 12'h000;
		end else if (st.cnt == PWR_ON_LAST) begin
			next_st.pwrOn = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 12'h001;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			st <= SLOT_RST;
		else
			st <= next_st;
	end

	a_cmd_event: assert property (@(posedge clk) disable iff (!rstn)
		wrEn && sin.hotplugCapable && wdata[SC_IND_LO +: 2] != IND_KEEP
		|=> st.status[4] && st.indicator == $past(wdata[SC_IND_LO +: 2]))
		else $error("Indicator write raised no command completion.");
	a_keep_ind: assert property (@(posedge clk) disable iff (!rstn)
		wrEn && wdata[SC_IND_LO +: 2] == IND_KEEP |=> st.indicator == $past(st.indicator))
		else $error("Zero indicator write changed the indicator.");
	a_fault_flag: assert property (@(posedge clk) disable iff (!rstn)
		sin.hotplugCapable && sin.powerFault |=> st.status[1])
		else $error("Power fault not flagged.");
	a_turnoff_first: assert property (@(posedge clk) disable iff (!rstn)
		st.turnOff |-> st.pwrCtrl ##1 !st.pwrOn)
		else $error("Slot not powered off after the turn-off message.");
	a_power_delay: assert property (@(posedge clk) disable iff (!rstn)
		$fell(st.pwrCtrl) |-> !st.pwrOn [*8])
		else $error("Slot power came on without delay.");
	a_wake_set: assert property (@(posedge clk) disable iff (!rstn)
		sin.powerState == DSTATE_D3HOT && sin.hotplugCapable && sin.buttonPress
		|=> st.wakeEventFlag)
		else $error("Wake flag not set by a slot event.");
	a_fault_irq: assert property (@(posedge clk) disable iff (!rstn)
		faultNote && sin.powerState == DSTATE_D0 |=> st.irq && !st.pme)
		else $error("Fault in D0 gave no interrupt.");
endmodule

// File: src/switch_port_power_mgmt.sv
// Power-management tracking of one upstream and several downstream switch ports.
// Assumes all link and slot inputs are synchronous to clk and config requests are strobes.
`timescale 1ns/1ns

// How it works
// - Hot-plug power fault notifies by interrupt or message
// - Non-zero indicator write completes a command on hot-plug slots
// - Indicator field reads its present state
// - Power control bit clear powers slot later
// - Hot-plug slot power fault sets its status bit
// - Budget header holds fixed id and pointer
// - Index select picks one of eight words
// - Budget words carry base power and scale
// - Budget words carry state, type and rail
// - System allocated bit marks included budget
// - Idle select picks one or four microseconds
// - Turn-off message precedes downstream power removal
// - Block bit stops standby entry
// - Upstream standby needs all enabled receivers standby
// - Upstream sleep needs all downstream sleeping
// - Downstream sleep exit wakes the upstream
// - Upstream receiver wake wakes sleeping downstream
// - One acknowledge after all active acknowledges
// - All downstream ready sends upstream enter
// - Hot-plug events set wake flag in D3hot
// - Non-hot-plug presence or link change wakes
// - Wake flag sends message when enabled
module switch_port_power_mgmt
	import pm_pkg::*;
(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rstn,
	// Configuration access
	input  wire logic               cfgReq,
	input  wire logic               cfgWrite,
	input  wire logic [1:0]         cfgPort,
	input  wire logic [11:0]        cfgAddr,
	input  wire logic [31:0]        cfgWdata,
	output logic                    cfgAck,
	output logic [31:0]             cfgRdata,
	// Power budget load
	input  wire logic               pbLoadWe,
	input  wire logic [3:0]         pbLoadIdx,
	input  wire logic [31:0]        pbLoadData,
	// Upstream link
	input  wire logic               upIdle,
	input  wire logic               upL1Req,
	input  wire logic               upRxIdleExit,
	input  wire logic               upTurnOffRx,
	output up_e                     upState,
	output logic                    upAckSend,
	output logic                    upEnterL23,
	output logic                    nontransparentBridgePortDown,
	// Downstream links
	input  wire link_e [NDS-1:0]    dsLink,
	input  wire logic [NDS-1:0]     dsRxEnabled,
	input  wire logic [NDS-1:0]     dsL1ExitBegin,
	input  wire logic [NDS-1:0]     dsAckRx,
	output logic [NDS-1:0]          dsL1Exit,
	// Slots
	input  wire slot_in_s [NDS-1:0] slotIn,
	output logic [NDS-1:0]          slotPowerOn,
	output logic [2*NDS-1:0]        powerIndicator,
	output logic [NDS-1:0]          slotIrq,
	output logic [NDS-1:0]          pmeSend,
	output logic [NDS-1:0]          turnOffSend,
	output logic [NDS-1:0]          wakeEventFlag
);
	main_st_s       st;
	main_st_s       next_st;
	idle_st_s       idleSt;
	slot_st_s       sst [NDS];
	logic [31:0]    slotWord [NDS];
	logic [NDS-1:0] slotWr;
	logic [NDS-1:0] dsDown;
	logic [NDS-1:0] dsInL1;
	logic           allRx;
	logic           allL1;
	logic           allL23;
	logic           anyDsExit;
	logic [NDS-1:0] ackedNow;
	logic           allAcked;
	logic [31:0]    readWord;
	logic [1:0]     rstPipe;
	logic           rstSyncN;

	function automatic logic slotHit(input logic [11:0] addr, input logic [1:0] port);
		return (port != 2'h0) && (addr == OFF_SLOT);
	endfunction

	function automatic logic upHit(input logic [11:0] addr, input logic [1:0] port,
		input logic [11:0] off);
		return (port == 2'h0) && (addr == off);
	endfunction

	// Reset is released through two flops so that release is clean on clk.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rstPipe <= 2'h0;
		else
			rstPipe <= {rstPipe[0], 1'b1};
	end
	assign rstSyncN = rstPipe[1];

	idle_timer uIdle (
		.clk     (clk),
		.rstn    (rstSyncN),
		.idle    (upIdle),
		.longSel (st.idleSel),
		.st      (idleSt)
	);

	genvar g;
	generate
		for (g = 0; g < NDS; g++) begin : gSlot
			slot_event_unit uSlot (
				.clk       (clk),
				.rstn      (rstSyncN),
				.wrEn      (slotWr[g]),
				.wdata     (cfgWdata),
				.turnoffEn (st.turnoffEn),
				.sin       (slotIn[g]),
				.st        (sst[g])
			);
			assign slotWr[g] = cfgReq && cfgWrite && slotHit(cfgAddr, cfgPort)
				&& (cfgPort == 2'(g + 1));
			assign slotWord[g] = {11'h000, sst[g].status, 5'h00, sst[g].pwrCtrl,
				sst[g].indicator, 6'h00, sst[g].faultEn, 1'b0};
			assign slotPowerOn[g] = sst[g].pwrOn;
			assign powerIndicator[2*g +: 2] = sst[g].indicator;
			assign slotIrq[g] = sst[g].irq;
			assign pmeSend[g] = sst[g].pme;
			assign turnOffSend[g] = sst[g].turnOff;
			assign wakeEventFlag[g] = sst[g].wakeEventFlag;
		end
	endgenerate

	// Aggregate downstream link conditions.
	always_comb begin
		allRx = 1'b1;
		allL1 = 1'b1;
		allL23 = 1'b1;
		anyDsExit = 1'b0;
		for (int i = 0; i < NDS; i++) begin
			dsDown[i] = dsLink[i] == LNK_DOWN;
			dsInL1[i] = dsLink[i] == LNK_L1;
			if (dsRxEnabled[i] && !(dsLink[i] inside {LNK_L0S, LNK_L1, LNK_L23, LNK_DOWN}))
				allRx = 1'b0;
			if (!(dsLink[i] inside {LNK_L1, LNK_L23, LNK_DOWN}))
				allL1 = 1'b0;
			if (!(dsLink[i] inside {LNK_L23, LNK_DOWN}))
				allL23 = 1'b0;
			if (dsInL1[i] && dsL1ExitBegin[i])
				anyDsExit = 1'b1;
		end
		ackedNow = st.acked | dsAckRx;
		allAcked = &(ackedNow | dsDown);
	end

	// Register read mux; unmapped offsets and other ports read zero, except the user register, which reads on every port.
	always_comb begin
		readWord = 32'h0000_0000;
		if (slotHit(cfgAddr, cfgPort))
			readWord = slotWord[2'(cfgPort - 2'h1)];
		else if (upHit(cfgAddr, cfgPort, OFF_PB_HDR))
			readWord = {PB_NEXT, PB_VER, PB_CAP_ID};
		else if (upHit(cfgAddr, cfgPort, OFF_PB_SEL))
			readWord = {24'h00_0000, st.pbIndex};
		else if (upHit(cfgAddr, cfgPort, OFF_PB_DATA))
			readWord = (st.pbIndex < 8'(PB_WORDS)) ? st.pb[st.pbIndex[2:0]] : 32'h0000_0000;
		else if (upHit(cfgAddr, cfgPort, OFF_PB_CAP))
			readWord = {31'h0000_0000, st.sysAlloc};
		else if (cfgAddr == OFF_USER)
			readWord = {21'h00_0000, st.standbyBlock, 7'h00, st.turnoffEn, 1'b0, st.idleSel};
	end

	always_comb begin
		next_st = st;
		next_st.upAck = 1'b0;
		next_st.dsL1Exit = '0;
		next_st.ack = cfgReq;
		if (cfgReq && !cfgWrite)
			next_st.rdata = readWord;
		if (cfgReq && cfgWrite) begin
			if (upHit(cfgAddr, cfgPort, OFF_PB_SEL))
				next_st.pbIndex = cfgWdata[7:0];
			if (cfgAddr == OFF_USER) begin
				next_st.idleSel = cfgWdata[UC_IDLE_SEL];
				next_st.turnoffEn = cfgWdata[UC_TURNOFF_EN];
				next_st.standbyBlock = cfgWdata[UC_BLOCK];
			end
		end
		// Budget words are loaded from the side; fields follow the budget word layout.
		if (pbLoadWe) begin
			if (pbLoadIdx < 4'(PB_WORDS))
				next_st.pb[pbLoadIdx[2:0]] = pb_word_s'(pbLoadData);
			else
				next_st.sysAlloc = pbLoadData[0];
		end

		case (st.up)
			UP_L0: begin
				if (upL1Req && allL1)
					next_st.up = UP_L1;
				else if (idleSt.met && !st.standbyBlock && allRx)
					next_st.up = UP_L0S;
			end
			UP_L0S: begin
				if (upL1Req && allL1)
					next_st.up = UP_L1;
				else if (!upIdle)
					next_st.up = UP_L0;
			end
			UP_L1: begin
				if (anyDsExit || upRxIdleExit)
					next_st.up = UP_L0;
				if (upRxIdleExit)
					next_st.dsL1Exit = dsInL1;
			end
			default: begin
				next_st.up = UP_L0;
			end
		endcase

		// A turn-off request from above re-arms the acknowledge collection.
		if (upTurnOffRx) begin
			next_st.toArmed = 1'b1;
			next_st.acked = '0;
			next_st.ackSent = 1'b0;
			next_st.portDown = 1'b0;
		end else if (st.toArmed) begin
			next_st.acked = ackedNow;
			if (allAcked) begin
				next_st.upAck = 1'b1;
				next_st.portDown = 1'b1;
				next_st.toArmed = 1'b0;
				next_st.ackSent = 1'b1;
			end
		end
		// Entry is held off until the acknowledge went up, or idle links would trigger it.
		next_st.enterL23 = st.ackSent && allL23 && !upTurnOffRx;
	end

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN)
			st <= MAIN_RST;
		else
			st <= next_st;
	end

	assign cfgAck = st.ack;
	assign cfgRdata = st.rdata;
	assign upState = st.up;
	assign upAckSend = st.upAck;
	assign upEnterL23 = st.enterL23;
	assign nontransparentBridgePortDown = st.portDown;
	assign dsL1Exit = st.dsL1Exit;

	a_standby_entry: assert property (@(posedge clk) disable iff (!rstSyncN)
		st.up != UP_L0S ##1 st.up == UP_L0S |-> $past(allRx) && $past(idleSt.met))
		else $error("Upstream entered standby with a busy receiver.");
	a_standby_block: assert property (@(posedge clk) disable iff (!rstSyncN)
		st.standbyBlock && st.up == UP_L0 |=> st.up != UP_L0S)
		else $error("Standby entered while blocked.");
	a_sleep_entry: assert property (@(posedge clk) disable iff (!rstSyncN)
		st.up != UP_L1 ##1 st.up == UP_L1 |-> $past(allL1) && $past(upL1Req))
		else $error("Upstream slept while a downstream port was awake.");
	a_up_exit: assert property (@(posedge clk) disable iff (!rstSyncN)
		st.up == UP_L1 && anyDsExit |=> st.up == UP_L0)
		else $error("Upstream stayed asleep after a downstream exit.");
	a_ds_exit: assert property (@(posedge clk) disable iff (!rstSyncN)
		st.up == UP_L1 && upRxIdleExit |=> dsL1Exit == $past(dsInL1) && st.up == UP_L0)
		else $error("Downstream ports not woken by upstream exit.");
	a_ack_single: assert property (@(posedge clk) disable iff (!rstSyncN)
		$rose(upAckSend) |-> nontransparentBridgePortDown ##1 !upAckSend)
		else $error("Acknowledge not single or port not marked down.");
	a_ack_wait: assert property (@(posedge clk) disable iff (!rstSyncN)
		st.toArmed && !allAcked && !upTurnOffRx |=> !upAckSend)
		else $error("Acknowledge sent before all active ports answered.");
	a_enter_l23: assert property (@(posedge clk) disable iff (!rstSyncN)
		st.ackSent && allL23 && !upTurnOffRx |=> upEnterL23)
		else $error("Upstream did not request the ready state.");
	a_pb_header: assert property (@(posedge clk) disable iff (!rstSyncN)
		cfgReq && !cfgWrite && cfgPort == 2'h0 && cfgAddr == OFF_PB_HDR
		|=> cfgAck && cfgRdata == {PB_NEXT, PB_VER, PB_CAP_ID})
		else $error("Budget header read wrong.");
	a_pb_select: assert property (@(posedge clk) disable iff (!rstSyncN)
		cfgReq && !cfgWrite && cfgPort == 2'h0 && cfgAddr == OFF_PB_DATA && st.pbIndex == 8'h03
		|=> cfgRdata == $past(st.pb[3]))
		else $error("Budget word not chosen by index.");
endmodule

// File: testbench/link_partner.sv
// Behavioural far side of the downstream links: link states and turn-off acknowledges.
// Assumes the bench selects the common state of the live links and which links are down.
`timescale 1ns/1ns
module link_partner
	import pm_pkg::*;
(
	// Clock
	input  wire logic             clk,
	// Bench control
	input  wire logic             turnOff,
	input  wire link_e            mode,
	input  wire logic [NDS-1:0]   down,
	// Links
	output link_e [NDS-1:0]       dsLink,
	output logic [NDS-1:0]        dsAckRx
);
	int cnt [NDS];

	initial begin
		dsLink = '0;
		dsAckRx = '0;
	end
	// Ports answer at different delays so the switch must wait for the slowest one.
	always @(posedge clk) begin
		for (int g = 0; g < NDS; g++) begin
			dsLink[g] <= down[g] ? LNK_DOWN : mode;
			dsAckRx[g] <= 1'b0;
			if (turnOff && !down[g]) begin
				cnt[g] <= 2 + 8 * g;
			end else if (cnt[g] > 0) begin
				cnt[g] <= cnt[g] - 1;
				dsAckRx[g] <= (cnt[g] == 1);
			end
		end
	end
endmodule

// File: testbench/switch_port_power_mgmt_bench.sv
// Self-checking bench for the switch power-management block.
// Assumes the link partner model and the shared package are compiled first.
`timescale 1ns/1ns
module switch_port_power_mgmt_bench
	import pm_pkg::*;
;
	logic               clk = 0, rstn = 0, cfgReq = 0, cfgWrite = 0, pbLoadWe = 0;
	logic [1:0]         cfgPort = 0;
	logic [11:0]        cfgAddr = 0;
	logic [31:0]        cfgWdata = 0, pbLoadData = 0, cfgRdata, rd;
	logic [3:0]         pbLoadIdx = 0;
	logic               upIdle = 0, upL1Req = 0, upRxIdleExit = 0, upTurnOffRx = 0;
	logic               cfgAck, upAckSend, upEnterL23, ntDown;
	up_e                upState;
	link_e              mode = LNK_L0;
	link_e [NDS-1:0]    dsLink;
	logic [NDS-1:0]     down = 0, rxEn = '1, exitBegin = 0, dsAckRx, dsL1Exit, slotPowerOn;
	logic [NDS-1:0]     slotIrq, pmeSend, turnOffSend, wakeEventFlag;
	logic [2*NDS-1:0]   powerIndicator;
	slot_in_s [NDS-1:0] slotIn = '{'0, '{hotplugCapable: 1'b1, default: '0},
		'{hotplugCapable: 1'b1, default: '0}};
	logic [NDS-1:0]     exitSeen = 0, irqSeen = 0, pmeSeen = 0, offSeen = 0;
	int                 ackCnt = 0, num_errors = 0, cmp_count = 0;

	always #25 clk = ~clk;
	// Output pulses are latched so that a check does not hinge on one exact cycle.
	always @(posedge clk) begin
		exitSeen <= exitSeen | dsL1Exit;
		irqSeen <= irqSeen | slotIrq;
		pmeSeen <= pmeSeen | pmeSend;
		offSeen <= offSeen | turnOffSend;
		ackCnt <= ackCnt + int'(upAckSend);
	end

	switch_port_power_mgmt switch_port_power_mgmt_i (.clk(clk), .rstn(rstn), .cfgReq(cfgReq),
		.cfgWrite(cfgWrite), .cfgPort(cfgPort), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata),
		.cfgAck(cfgAck), .cfgRdata(cfgRdata), .pbLoadWe(pbLoadWe), .pbLoadIdx(pbLoadIdx),
		.pbLoadData(pbLoadData), .upIdle(upIdle), .upL1Req(upL1Req),
		.upRxIdleExit(upRxIdleExit), .upTurnOffRx(upTurnOffRx), .upState(upState),
		.upAckSend(upAckSend), .upEnterL23(upEnterL23), .nontransparentBridgePortDown(ntDown),
		.dsLink(dsLink), .dsRxEnabled(rxEn), .dsL1ExitBegin(exitBegin), .dsAckRx(dsAckRx),
		.dsL1Exit(dsL1Exit), .slotIn(slotIn), .slotPowerOn(slotPowerOn),
		.powerIndicator(powerIndicator), .slotIrq(slotIrq), .pmeSend(pmeSend),
		.turnOffSend(turnOffSend), .wakeEventFlag(wakeEventFlag));
	link_partner link_partner_i (.clk(clk), .turnOff(upTurnOffRx), .mode(mode), .down(down),
		.dsLink(dsLink), .dsAckRx(dsAckRx));

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task cfg(input logic w, input logic [1:0] p, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		cfgReq <= 1'b1;
		cfgWrite <= w;
		cfgPort <= p;
		cfgAddr <= a;
		cfgWdata <= d;
		@(posedge clk);
		cfgReq <= 1'b0;
		#1 rd = cfgRdata;
		chk("cfgAck", 32'(cfgAck), 32'h1);
	endtask
	task rdchk(input string n, input logic [1:0] p, input logic [11:0] a, input logic [31:0] e);
		cfg(1'b0, p, a, 32'h0);
		chk(n, rd, e);
	endtask
	task pbload(input logic [3:0] idx, input logic [31:0] d);
		@(posedge clk);
		pbLoadWe <= 1'b1;
		pbLoadIdx <= idx;
		pbLoadData <= d;
		@(posedge clk);
		pbLoadWe <= 1'b0;
	endtask

	task t_regs;
		rdchk("slot reset", 2'h2, OFF_SLOT, 32'h0000_0700);
		rdchk("pb header", 2'h0, OFF_PB_HDR, 32'h1481_0004);
		rdchk("user reset", 2'h0, OFF_USER, 32'h0);
		rdchk("unmapped", 2'h0, 12'h100, 32'h0);
	endtask
	task t_indicator;
		cfg(1'b1, 2'h2, OFF_SLOT, 32'h0000_0500);
		rdchk("ind on", 2'h2, OFF_SLOT, 32'h0010_0500);
		chk("ind pin", 32'(powerIndicator[3:2]), 32'h1);
		cfg(1'b1, 2'h2, OFF_SLOT, 32'h0010_0400);
		rdchk("ind keep", 2'h2, OFF_SLOT, 32'h0000_0500);
		cfg(1'b1, 2'h2, OFF_SLOT, 32'h0000_0600);
		rdchk("ind blink", 2'h2, OFF_SLOT, 32'h0010_0600);
		cfg(1'b1, 2'h2, OFF_SLOT, 32'h0010_0600);
		rdchk("ind same", 2'h2, OFF_SLOT, 32'h0010_0600);
		cfg(1'b1, 2'h2, OFF_SLOT, 32'h0010_0400);
	endtask
	task t_budget;
		pbload(4'h3, 32'h001f_e319);
		pbload(4'h7, 32'h0000_0105);
		pbload(4'h8, 32'h1);
		cfg(1'b1, 2'h0, OFF_PB_SEL, 32'h3);
		rdchk("select", 2'h0, OFF_PB_SEL, 32'h3);
		rdchk("word 3", 2'h0, OFF_PB_DATA, 32'h001f_e319);
		cfg(1'b1, 2'h0, OFF_PB_SEL, 32'h7);
		rdchk("word 7", 2'h0, OFF_PB_DATA, 32'h0000_0105);
		rdchk("sys alloc", 2'h0, OFF_PB_CAP, 32'h1);
	endtask
	task t_standby;
		mode <= LNK_L0S;
		upIdle <= 1'b1;
		cyc(15);
		chk("short early", 32'(upState), 32'(UP_L0));
		cyc(10);
		chk("short entry", 32'(upState), 32'(UP_L0S));
		upIdle <= 1'b0;
		cfg(1'b1, 2'h0, OFF_USER, 32'h1);
		chk("standby exit", 32'(upState), 32'(UP_L0));
		upIdle <= 1'b1;
		cyc(60);
		chk("long early", 32'(upState), 32'(UP_L0));
		cyc(30);
		chk("long entry", 32'(upState), 32'(UP_L0S));
		upIdle <= 1'b0;
		cfg(1'b1, 2'h0, OFF_USER, 32'h400);
		upIdle <= 1'b1;
		cyc(100);
		chk("blocked", 32'(upState), 32'(UP_L0));
		upIdle <= 1'b0;
		cfg(1'b1, 2'h0, OFF_USER, 32'h0);
	endtask
	task t_sleep;
		mode <= LNK_L1;
		upL1Req <= 1'b1;
		cyc(3);
		chk("sleep", 32'(upState), 32'(UP_L1));
		upL1Req <= 1'b0;
		exitBegin <= 3'b001;
		cyc(1);
		exitBegin <= 3'b000;
		cyc(3);
		chk("ds wake", 32'(upState), 32'(UP_L0));
		upL1Req <= 1'b1;
		cyc(3);
		upL1Req <= 1'b0;
		upRxIdleExit <= 1'b1;
		cyc(1);
		upRxIdleExit <= 1'b0;
		cyc(3);
		chk("up wake", 32'(exitSeen), 32'h7);
		mode <= LNK_L0;
	endtask
	task t_wake;
		chk("no flag D0", 32'(wakeEventFlag[1]), 32'h0);
		slotIn[1].powerState <= DSTATE_D3HOT;
		slotIn[1].wakeMessageEnable <= 1'b1;
		slotIn[1].buttonPress <= 1'b1;
		slotIn[2].powerState <= DSTATE_D3HOT;
		slotIn[2].dllChange <= 1'b1;
		cyc(1);
		slotIn[1].buttonPress <= 1'b0;
		slotIn[2].dllChange <= 1'b0;
		cyc(2);
		chk("hp flag", 32'(wakeEventFlag[1]), 32'h1);
		chk("pme sent", 32'(pmeSeen[1]), 32'h1);
		chk("nhp flag", 32'(wakeEventFlag[2]), 32'h1);
		chk("pme gated", 32'(pmeSeen[2]), 32'h0);
		slotIn[1].powerState <= DSTATE_D0;
		cfg(1'b1, 2'h2, OFF_SLOT, 32'h0001_0402);
		slotIn[1].powerFault <= 1'b1;
		cyc(1);
		slotIn[1].powerFault <= 1'b0;
		rdchk("fault", 2'h2, OFF_SLOT, 32'h0002_0602);
		chk("fault irq", 32'(irqSeen[1]), 32'h1);
		slotIn[1].wakeClear <= 1'b1;
		cyc(1);
		slotIn[1].wakeClear <= 1'b0;
		cyc(1);
		chk("flag clear", 32'(wakeEventFlag[1]), 32'h0);
	endtask
	task t_power;
		cfg(1'b1, 2'h1, OFF_SLOT, 32'h0);
		cyc(PWR_ON_CYC - 10);
		chk("power early", 32'(slotPowerOn[0]), 32'h0);
		cyc(20);
		chk("power on", 32'(slotPowerOn[0]), 32'h1);
		cfg(1'b1, 2'h0, OFF_USER, 32'h4);
		cfg(1'b1, 2'h1, OFF_SLOT, 32'h400);
		cyc(2);
		chk("turnoff msg", 32'(offSeen[0]), 32'h1);
		chk("power off", 32'(slotPowerOn[0]), 32'h0);
	endtask
	task t_ack;
		down <= 3'b100;
		cyc(3);
		upTurnOffRx <= 1'b1;
		cyc(1);
		upTurnOffRx <= 1'b0;
		cyc(6);
		chk("ack early", 32'(ackCnt), 32'h0);
		cyc(20);
		chk("ack once", 32'(ackCnt), 32'h1);
		chk("nt down", 32'(ntDown), 32'h1);
		chk("no l23", 32'(upEnterL23), 32'h0);
		mode <= LNK_L23;
		cyc(4);
		chk("enter l23", 32'(upEnterL23), 32'h1);
	endtask

	task conclude;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		#1000000;
		num_errors++;
		conclude();
	end
	initial begin
		cyc(10);
		rstn <= 1'b1;
		cyc(3);
		t_regs();
		t_indicator();
		t_budget();
		t_standby();
		t_sleep();
		t_wake();
		t_power();
		t_ack();
		conclude();
	end
endmodule
